/* File: logic/ach_defs.svh */
// register offsets, reset values and field positions of the cell header bank
`ifndef ACH_DEFS_SVH
`define ACH_DEFS_SVH

// register offsets on the byte-wide register port
`define ACH_OFF_HDR_CTRL 6'h09
`define ACH_OFF_TX_HDR3 6'h12
`define ACH_OFF_TX_HDR4 6'h13
`define ACH_OFF_IDLE1 6'h14
`define ACH_OFF_IDLE2 6'h15
`define ACH_OFF_IDLE3 6'h16
`define ACH_OFF_IDLE4 6'h17
`define ACH_OFF_RX_MATCH1 6'h18
`define ACH_OFF_RX_MATCH2 6'h19
`define ACH_OFF_RX_MATCH3 6'h1a
`define ACH_OFF_RX_MATCH4 6'h1b
`define ACH_OFF_RX_MASK1 6'h1c
`define ACH_OFF_RX_MASK4 6'h1f
`define ACH_OFF_ACC_CNT 6'h30
`define ACH_OFF_REJ_CNT 6'h31

// contiguous header bank
`define ACH_BANK_FIRST 6'h12
`define ACH_BANK_LAST 6'h1f
`define ACH_BANK_N 14

// reset values
`define ACH_RST_BYTE 8'h00
`define ACH_RST_IDLE4 8'h01
`define ACH_RST_MASK 8'hff
`define ACH_RST_CTRL 8'h00

// insertion control bit positions and implemented bits
`define ACH_CTRL_OCT3_VCI 0
`define ACH_CTRL_OCT4_VCI 1
`define ACH_CTRL_OCT4_PT 2
`define ACH_CTRL_OCT4_CLP 3
`define ACH_CTRL_USED 8'h0f

// octet 4 field layout
`define ACH_OCT4_VCI_MSK 8'hf0
`define ACH_OCT4_PT_MSK 8'h0e
`define ACH_OCT4_CLP_MSK 8'h01

`endif

/* File: logic/ach_pkg.sv */
// types shared by the cell header bank and its screening comparator
`default_nettype none
package ach_pkg;
    typedef logic [7:0] ach_byte_t;

    // four header octets, octet 1 in the upper byte
    typedef struct packed {
        ach_byte_t oct1;
        ach_byte_t oct2;
        ach_byte_t oct3;
        ach_byte_t oct4;
    } ach_hdr_t;

    // transmit cell header slot
    typedef struct packed {
        logic valid;
        logic idle;
        ach_hdr_t hdr;
    } ach_tx_cell_t;

    // receive cell header slot
    typedef struct packed {
        logic valid;
        ach_hdr_t hdr;
    } ach_rx_cell_t;

    // register port access kind
    typedef enum logic [1:0] {
        ACH_ACC_IDLE = 2'b00,
        ACH_ACC_WRITE = 2'b01,
        ACH_ACC_READ = 2'b10
    } ach_acc_t;
endpackage
`default_nettype wire

/* File: logic/ach_screen.sv */
// masked comparison of a received cell header against the match value
`timescale 1ns/1ps
`default_nettype none
module ach_screen
    import ach_pkg::*;
#(
    parameter int N_OCT = 4
) (
    input wire ach_hdr_t hdr_i,
    input wire ach_hdr_t match_i,
    input wire ach_hdr_t mask_i,
    output logic hit_o
);

    ////////////////////////////////////////////////////////////////////////
    // a header always has four octets before the check octet
    if (N_OCT != 4) begin : g_bad_oct
        $error("ach_screen: N_OCT must be 4");
    end

    // one octet hits when every unmasked bit equals the match bit
    function automatic logic octet_hit(input ach_byte_t got, input ach_byte_t want,
                                       input ach_byte_t ign);
        octet_hit = &((~(got ^ want)) | ign);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // per-octet compare, the check octet is not presented here
    logic [N_OCT-1:0] oct_hit;
    for (genvar g = 0; g < N_OCT; g++) begin : g_oct
        assign oct_hit[g] = octet_hit(hdr_i[8*g +: 8], match_i[8*g +: 8],
                                      mask_i[8*g +: 8]);
    end

    // all four octets must hit
    assign hit_o = &oct_hit;

endmodule
`default_nettype wire

/* File: logic/ach_regs.sv */
// per-port cell header register bank with transmit insertion and receive screening
// Notes on behaviour
// - octet 3 of assigned cells from register
// - octet 4 fields: channel, payload type, priority
// - idle cells carry the four idle bytes
// - idle byte 1 becomes outgoing octet 1
// - idle byte 2 becomes outgoing octet 2
// - idle byte 3 becomes outgoing octet 3
// - idle byte 4 is octet 4, resets 0x01
// - accept cell only on header match
// - mask registers qualify the header comparison
// - match bytes 1 and 2 reset to zero
// - set mask bit ignores that header bit
`timescale 1ns/1ps
`default_nettype none
`include "ach_defs.svh"
module ach_regs
    import ach_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // transmit header path
    input wire ach_tx_cell_t tx_cell_i,
    output ach_tx_cell_t tx_cell_o,
    // receive screening path
    input wire ach_rx_cell_t rx_cell_i,
    output logic rx_accept_o,
    output logic rx_reject_o,
    output ach_hdr_t rx_hdr_o
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (ADDR_W < 6) begin : g_bad_addr
        $error("ach_regs: ADDR_W must be at least 6");
    end

    localparam int BANK_N = `ACH_BANK_N;
    localparam logic [ADDR_W-1:0] A_FIRST = ADDR_W'(`ACH_BANK_FIRST);
    localparam logic [ADDR_W-1:0] A_LAST = ADDR_W'(`ACH_BANK_LAST);
    localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'(`ACH_OFF_HDR_CTRL);
    localparam logic [ADDR_W-1:0] A_ACC = ADDR_W'(`ACH_OFF_ACC_CNT);
    localparam logic [ADDR_W-1:0] A_REJ = ADDR_W'(`ACH_OFF_REJ_CNT);
    localparam logic [ADDR_W-1:0] A_IDLE4 = ADDR_W'(`ACH_OFF_IDLE4);
    localparam logic [ADDR_W-1:0] A_RXM1 = ADDR_W'(`ACH_OFF_RX_MATCH1);
    localparam logic [ADDR_W-1:0] A_RXM2 = ADDR_W'(`ACH_OFF_RX_MATCH2);

    // bank slot of each register
    localparam int I_TXH3 = `ACH_OFF_TX_HDR3 - `ACH_BANK_FIRST;
    localparam int I_TXH4 = `ACH_OFF_TX_HDR4 - `ACH_BANK_FIRST;
    localparam int I_IDL1 = `ACH_OFF_IDLE1 - `ACH_BANK_FIRST;
    localparam int I_IDL2 = `ACH_OFF_IDLE2 - `ACH_BANK_FIRST;
    localparam int I_IDL3 = `ACH_OFF_IDLE3 - `ACH_BANK_FIRST;
    localparam int I_IDL4 = `ACH_OFF_IDLE4 - `ACH_BANK_FIRST;
    localparam int I_RXM1 = `ACH_OFF_RX_MATCH1 - `ACH_BANK_FIRST;
    localparam int I_RXM2 = `ACH_OFF_RX_MATCH2 - `ACH_BANK_FIRST;
    localparam int I_RXM3 = `ACH_OFF_RX_MATCH3 - `ACH_BANK_FIRST;
    localparam int I_RXM4 = `ACH_OFF_RX_MATCH4 - `ACH_BANK_FIRST;
    localparam int I_MSK1 = `ACH_OFF_RX_MASK1 - `ACH_BANK_FIRST;

    // reset value of a bank slot
    function automatic ach_byte_t bank_rst(input int idx);
        int off;
        off = idx + `ACH_BANK_FIRST;
        if (off == `ACH_OFF_IDLE4) begin
            bank_rst = `ACH_RST_IDLE4;
        end else if (off >= `ACH_OFF_RX_MASK1) begin
            bank_rst = `ACH_RST_MASK;
        end else begin
            bank_rst = `ACH_RST_BYTE;
        end
    endfunction

    // replace the bits selected by sel with the register bits
    function automatic ach_byte_t merge(input ach_byte_t orig, input ach_byte_t ins,
                                        input ach_byte_t sel);
        merge = (orig & ~sel) | (ins & sel);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // access decode
    ach_acc_t acc;
    wire logic wr_en;
    wire logic rd_en;
    assign acc = reg_wr_i ? ACH_ACC_WRITE : (reg_rd_i ? ACH_ACC_READ : ACH_ACC_IDLE);
    assign wr_en = (acc == ACH_ACC_WRITE);
    assign rd_en = (acc == ACH_ACC_READ);

    ////////////////////////////////////////////////////////////////////////
    // header bank, one byte per slot
    ach_byte_t bank [BANK_N];
    for (genvar g = 0; g < BANK_N; g++) begin : g_bank
        localparam ach_byte_t RST = bank_rst(g);
        localparam logic [ADDR_W-1:0] OFF = ADDR_W'(`ACH_BANK_FIRST + g);
        ach_byte_t byte_q;
        wire logic hit;
        assign hit = wr_en && (reg_addr_i == OFF);
        // write on address hit
        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                byte_q <= RST;
            end else if (hit) begin
                byte_q <= reg_wdata_i;
            end
        end
        assign bank[g] = byte_q;
    end

    // insertion control, unused bits read zero
    ach_byte_t header_insert_control_q;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            header_insert_control_q <= `ACH_RST_CTRL;
        end else if (wr_en && (reg_addr_i == A_CTRL)) begin
            header_insert_control_q <= reg_wdata_i & `ACH_CTRL_USED;
        end
    end

    // named views of the bank
    ach_byte_t tx_hdr_byte3_bits;
    ach_byte_t tx_hdr_byte4_bits;
    ach_byte_t idle_hdr_byte1_bits;
    ach_byte_t idle_hdr_byte2_bits;
    ach_byte_t idle_hdr_byte3_bits;
    ach_byte_t idle_hdr_byte4_bits;
    ach_byte_t rx_match_byte1_bits;
    ach_byte_t rx_match_byte2_bits;
    ach_hdr_t rx_match;
    ach_hdr_t rx_mask;
    assign tx_hdr_byte3_bits = bank[I_TXH3];
    assign tx_hdr_byte4_bits = bank[I_TXH4];
    assign idle_hdr_byte1_bits = bank[I_IDL1];
    assign idle_hdr_byte2_bits = bank[I_IDL2];
    assign idle_hdr_byte3_bits = bank[I_IDL3];
    assign idle_hdr_byte4_bits = bank[I_IDL4];
    assign rx_match_byte1_bits = bank[I_RXM1];
    assign rx_match_byte2_bits = bank[I_RXM2];
    assign rx_match = {rx_match_byte1_bits, rx_match_byte2_bits, bank[I_RXM3], bank[I_RXM4]};
    assign rx_mask = {bank[I_MSK1], bank[I_MSK1+1], bank[I_MSK1+2], bank[I_MSK1+3]};

    ////////////////////////////////////////////////////////////////////////
    // transmit header build
    ach_byte_t ins_sel3;
    ach_byte_t ins_sel4;
    ach_hdr_t assigned_hdr;
    ach_hdr_t idle_hdr;
    ach_tx_cell_t tx_d;
    ach_tx_cell_t tx_q;
    assign ins_sel3 = {8{header_insert_control_q[`ACH_CTRL_OCT3_VCI]}};
    assign ins_sel4 = ({8{header_insert_control_q[`ACH_CTRL_OCT4_VCI]}} & `ACH_OCT4_VCI_MSK)
        | ({8{header_insert_control_q[`ACH_CTRL_OCT4_PT]}} & `ACH_OCT4_PT_MSK)
        | ({8{header_insert_control_q[`ACH_CTRL_OCT4_CLP]}} & `ACH_OCT4_CLP_MSK);
    assign assigned_hdr.oct1 = tx_cell_i.hdr.oct1;
    assign assigned_hdr.oct2 = tx_cell_i.hdr.oct2;
    assign assigned_hdr.oct3 = merge(tx_cell_i.hdr.oct3, tx_hdr_byte3_bits, ins_sel3);
    assign assigned_hdr.oct4 = merge(tx_cell_i.hdr.oct4, tx_hdr_byte4_bits, ins_sel4);
    // idle header is the four idle bytes in octet order
    assign idle_hdr = {idle_hdr_byte1_bits, idle_hdr_byte2_bits,
                       idle_hdr_byte3_bits, idle_hdr_byte4_bits};
    assign tx_d.valid = tx_cell_i.valid;
    assign tx_d.idle = tx_cell_i.idle;
    assign tx_d.hdr = tx_cell_i.idle ? idle_hdr : assigned_hdr;

    // one-cycle transmit stage
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_q <= '0;
        end else begin
            tx_q <= tx_d;
        end
    end
    assign tx_cell_o = tx_q;

    ////////////////////////////////////////////////////////////////////////
    // receive screening
    wire logic rx_hit;
    ach_screen #(
        .N_OCT(4)
    ) u_screen (
        .hdr_i(rx_cell_i.hdr),
        .match_i(rx_match),
        .mask_i(rx_mask),
        .hit_o(rx_hit)
    );

    logic rx_accept_q;
    logic rx_reject_q;
    ach_hdr_t rx_hdr_q;
    ach_byte_t acc_cnt_q;
    ach_byte_t rej_cnt_q;
    wire logic rx_acc_d;
    wire logic rx_rej_d;
    assign rx_acc_d = rx_cell_i.valid && rx_hit;
    assign rx_rej_d = rx_cell_i.valid && !rx_hit;

    // accept and reject pulses, accepted header and wrapping counters
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_accept_q <= 1'b0;
            rx_reject_q <= 1'b0;
            rx_hdr_q <= '0;
            acc_cnt_q <= 8'h00;
            rej_cnt_q <= 8'h00;
        end else begin
            rx_accept_q <= rx_acc_d;
            rx_reject_q <= rx_rej_d;
            rx_hdr_q <= rx_acc_d ? rx_cell_i.hdr : rx_hdr_q;
            acc_cnt_q <= acc_cnt_q + {7'h00, rx_acc_d};
            rej_cnt_q <= rej_cnt_q + {7'h00, rx_rej_d};
        end
    end
    assign rx_accept_o = rx_accept_q;
    assign rx_reject_o = rx_reject_q;
    assign rx_hdr_o = rx_hdr_q;

    ////////////////////////////////////////////////////////////////////////
    // read path, data stand only in the cycle after the read strobe
    wire logic rd_in_bank;
    wire logic [3:0] rd_idx;
    ach_byte_t rd_val;
    ach_byte_t rdata_q;
    assign rd_in_bank = (reg_addr_i >= A_FIRST) && (reg_addr_i <= A_LAST);
    assign rd_idx = 4'(reg_addr_i - A_FIRST);
    assign rd_val = rd_in_bank ? bank[rd_idx]
                  : (reg_addr_i == A_CTRL) ? header_insert_control_q
                  : (reg_addr_i == A_ACC) ? acc_cnt_q
                  : (reg_addr_i == A_REJ) ? rej_cnt_q
                  : 8'h00;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_en ? rd_val : 8'h00;
        end
    end
    assign reg_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    // reference for the masked compare, independent of the comparator
    wire logic ref_match;
    assign ref_match = (((rx_cell_i.hdr ^ rx_match) & ~rx_mask) == 32'h0000_0000);

    // write history of registers with a checked reset value
    logic seen_idle4_q;
    logic seen_rxm1_q;
    logic seen_rxm2_q;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seen_idle4_q <= 1'b0;
            seen_rxm1_q <= 1'b0;
            seen_rxm2_q <= 1'b0;
        end else begin
            seen_idle4_q <= seen_idle4_q || (wr_en && reg_addr_i == A_IDLE4);
            seen_rxm1_q <= seen_rxm1_q || (wr_en && reg_addr_i == A_RXM1);
            seen_rxm2_q <= seen_rxm2_q || (wr_en && reg_addr_i == A_RXM2);
        end
    end

    oct3_insert_a: assert property (
        tx_cell_i.valid && !tx_cell_i.idle |=> tx_cell_o.valid
        && tx_cell_o.hdr.oct3 == ($past(header_insert_control_q[0])
        ? $past(tx_hdr_byte3_bits) : $past(tx_cell_i.hdr.oct3)))
        else $error("octet 3 insertion wrong");

    oct4_fields_a: assert property (
        tx_cell_i.valid && !tx_cell_i.idle |=>
        tx_cell_o.hdr.oct4[7:4] == ($past(header_insert_control_q[1])
        ? $past(tx_hdr_byte4_bits[7:4]) : $past(tx_cell_i.hdr.oct4[7:4]))
        && tx_cell_o.hdr.oct4[3:1] == ($past(header_insert_control_q[2])
        ? $past(tx_hdr_byte4_bits[3:1]) : $past(tx_cell_i.hdr.oct4[3:1])))
        else $error("octet 4 field insertion wrong");

    clp_insert_a: assert property (
        tx_cell_i.valid && !tx_cell_i.idle && header_insert_control_q[3]
        |=> tx_cell_o.hdr.oct4[0] == $past(tx_hdr_byte4_bits[0]))
        else $error("priority bit not inserted");

    idle_header_a: assert property (
        tx_cell_i.valid && tx_cell_i.idle |=> tx_cell_o.valid && tx_cell_o.idle
        && tx_cell_o.hdr == $past({idle_hdr_byte1_bits, idle_hdr_byte2_bits,
        idle_hdr_byte3_bits, idle_hdr_byte4_bits}))
        else $error("idle header not inserted");

    idle_octets_a: assert property (
        tx_cell_i.valid && tx_cell_i.idle |=>
        tx_cell_o.hdr.oct1 == $past(idle_hdr_byte1_bits)
        && tx_cell_o.hdr.oct2 == $past(idle_hdr_byte2_bits)
        && tx_cell_o.hdr.oct3 == $past(idle_hdr_byte3_bits))
        else $error("idle octet order wrong");

    idle4_reset_a: assert property (
        !seen_idle4_q |-> idle_hdr_byte4_bits == 8'h01)
        else $error("idle byte 4 reset value wrong");

    rx_reset_a: assert property (
        (!seen_rxm1_q |-> rx_match_byte1_bits == 8'h00)
        and (!seen_rxm2_q |-> rx_match_byte2_bits == 8'h00))
        else $error("match byte reset value wrong");

    rx_accept_a: assert property (
        rx_cell_i.valid && ref_match |=> rx_accept_o && !rx_reject_o
        && rx_hdr_o == $past(rx_cell_i.hdr))
        else $error("matching cell not accepted");

    rx_reject_a: assert property (
        rx_cell_i.valid && !ref_match |=> rx_reject_o && !rx_accept_o)
        else $error("mismatching cell not rejected");

    mask_ignore_a: assert property (
        rx_cell_i.valid && rx_mask == 32'hffff_ffff |=> rx_accept_o)
        else $error("fully masked cell rejected");

    read_latency_a: assert property (
        rd_en && reg_addr_i == A_IDLE4 |=> reg_rdata_o == $past(idle_hdr_byte4_bits)
        ##1 ($past(rd_en) || reg_rdata_o == 8'h00))
        else $error("read data timing wrong");

    idle_sent_c: cover property (tx_cell_i.valid && tx_cell_i.idle ##1 tx_cell_o.valid);
    insert_sent_c: cover property (tx_cell_i.valid && !tx_cell_i.idle
                                   && header_insert_control_q[0]);
    rx_accepted_c: cover property (rx_cell_i.valid && rx_mask != 32'hffff_ffff
                                   ##1 rx_accept_o);
    rx_rejected_c: cover property (rx_cell_i.valid ##1 rx_reject_o);

endmodule
`default_nettype wire

/* File: sim/ach_regs_tb.sv */
// self-checking testbench of the cell header register bank
`timescale 1ns/1ps
`default_nettype none
`include "ach_defs.svh"
module ach_regs_tb
    import ach_pkg::*;
;
    logic mclk_i;
    logic arst_n_i;
    logic [5:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [7:0] reg_rdata_o;
    ach_tx_cell_t tx_cell_i;
    ach_tx_cell_t tx_cell_o;
    ach_rx_cell_t rx_cell_i;
    logic rx_accept_o;
    logic rx_reject_o;
    ach_hdr_t rx_hdr_o;
    int error_cnt = 0;
    int checks_done = 0;

    ach_regs #(.ADDR_W(6)) dut (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .tx_cell_i(tx_cell_i),
        .tx_cell_o(tx_cell_o),
        .rx_cell_i(rx_cell_i),
        .rx_accept_o(rx_accept_o),
        .rx_reject_o(rx_reject_o),
        .rx_hdr_o(rx_hdr_o)
    );

    // 25 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // comparison and bus tasks

    // prints counts and verdict, then stops
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_hdr(input string what, input ach_hdr_t exp, input ach_hdr_t got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flag(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    // one-cycle write strobe
    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic chk_reg(input logic [5:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk_byte($sformatf("reg %h", a), exp, reg_rdata_o);
    endtask

    // one header into the transmit path, rebuilt header judged a cycle later
    task automatic send_tx(input logic idle, input ach_hdr_t h, input ach_hdr_t exp);
        @(posedge mclk_i);
        tx_cell_i <= {1'b1, idle, h};
        @(posedge mclk_i);
        tx_cell_i <= '0;
        #1;
        chk_flag("tx valid", 1'b1, tx_cell_o.valid);
        chk_flag("tx idle", idle, tx_cell_o.idle);
        chk_hdr("tx header", exp, tx_cell_o.hdr);
    endtask

    // one header into the screen, accept or reject judged a cycle later
    task automatic send_rx(input ach_hdr_t h, input logic acc, input ach_hdr_t exp_last);
        @(posedge mclk_i);
        rx_cell_i <= {1'b1, h};
        @(posedge mclk_i);
        rx_cell_i <= '0;
        #1;
        chk_flag("rx accept", acc, rx_accept_o);
        chk_flag("rx reject", ~acc, rx_reject_o);
        chk_hdr("rx last header", exp_last, rx_hdr_o);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios

    // reset values of the bank, an unmapped place and the default idle header
    task automatic t_reset();
        logic [7:0] rv [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00,
            8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff};
        for (int i = 0; i < 14; i++) begin
            chk_reg(6'h12 + 6'(i), rv[i]);
        end
        chk_reg(6'h20, 8'h00);
        send_tx(1'b1, 32'hffff_ffff, 32'h0000_0001);
        $display("test reset done");
    endtask

    // every transmit and idle register and match bytes 1 and 2 keep what was written
    task automatic t_rw();
        for (int a = 'h12; a <= 'h19; a++) begin
            reg_wr(6'(a), {a[3:0], ~a[3:0]});
            chk_reg(6'(a), {a[3:0], ~a[3:0]});
        end
        reg_wr(6'h20, 8'h5a);
        chk_reg(6'h20, 8'h00);
        $display("test write readback done");
    endtask

    // all sixteen insertion settings on an assigned cell
    task automatic t_insert();
        ach_hdr_t h;
        ach_hdr_t e;
        h = 32'h1122_5a39;
        reg_wr(`ACH_OFF_TX_HDR3, 8'ha5);
        reg_wr(`ACH_OFF_TX_HDR4, 8'hc6);
        for (int c = 0; c < 16; c++) begin
            reg_wr(`ACH_OFF_HDR_CTRL, 8'(c));
            e = h;
            e.oct3 = c[0] ? 8'ha5 : h.oct3;
            e.oct4 = ((c[1] ? 8'hc6 : h.oct4) & 8'hf0) | ((c[2] ? 8'hc6 : h.oct4) & 8'h0e)
                | ((c[3] ? 8'hc6 : h.oct4) & 8'h01);
            send_tx(1'b0, h, e);
        end
        reg_wr(`ACH_OFF_HDR_CTRL, 8'hff);
        chk_reg(`ACH_OFF_HDR_CTRL, 8'h0f);
        $display("test insertion done");
    endtask

    // idle header built from the four idle bytes in octet order
    task automatic t_idle();
        reg_wr(`ACH_OFF_IDLE1, 8'h11);
        reg_wr(`ACH_OFF_IDLE2, 8'h22);
        reg_wr(`ACH_OFF_IDLE3, 8'h33);
        reg_wr(`ACH_OFF_IDLE4, 8'h44);
        send_tx(1'b1, 32'h0000_0000, 32'h1122_3344);
        send_tx(1'b1, 32'hffff_ffff, 32'h1122_3344);
        $display("test idle header done");
    endtask

    // screening with open masks, exact match, single-bit misses and a masked bit
    task automatic t_rx();
        send_rx(32'hdead_beef, 1'b1, 32'hdead_beef);
        reg_wr(`ACH_OFF_RX_MATCH1, 8'h12);
        reg_wr(`ACH_OFF_RX_MATCH2, 8'h34);
        reg_wr(`ACH_OFF_RX_MATCH3, 8'h56);
        reg_wr(`ACH_OFF_RX_MATCH4, 8'h78);
        for (int i = 0; i < 4; i++) begin
            reg_wr(`ACH_OFF_RX_MASK1 + 6'(i), 8'h00);
        end
        send_rx(32'h1234_5678, 1'b1, 32'h1234_5678);
        send_rx(32'h9234_5678, 1'b0, 32'h1234_5678);
        send_rx(32'h1235_5678, 1'b0, 32'h1234_5678);
        send_rx(32'h1234_5679, 1'b0, 32'h1234_5678);
        reg_wr(`ACH_OFF_RX_MASK4, 8'h01);
        send_rx(32'h1234_5679, 1'b1, 32'h1234_5679);
        send_rx(32'h1234_5778, 1'b0, 32'h1234_5679);
        chk_reg(`ACH_OFF_ACC_CNT, 8'h03);
        chk_reg(`ACH_OFF_REJ_CNT, 8'h04);
        $display("test screening done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog

    initial begin
        arst_n_i = 1'b0;
        reg_addr_i = '0;
        reg_wdata_i = '0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        tx_cell_i = '0;
        rx_cell_i = '0;
        repeat (16) @(posedge mclk_i);
        @(negedge mclk_i);
        arst_n_i = 1'b1;
        t_reset();
        t_rw();
        t_insert();
        t_idle();
        t_rx();
        final_report();
    end

    // cuts a hang short
    initial begin
        for (int n = 0; n < 20000; n++) begin
            @(posedge mclk_i);
        end
        error_cnt++;
        $display("[ERR] run length expected below 20000 cycles seen 20000");
        final_report();
    end
endmodule
`default_nettype wire
